// ---- src/rftx_pkg.sv ----
/*
 * Constants and types of the RF transmitter rate and frame register bank.
 * Assumes an 8-bit register port addressed at the printed byte offsets.
 */
package rftx_pkg;
   // ****************************************
   // Register map
   // ****************************************
   localparam logic [15:0] RFTX_ADDR_RATE = 16'h1830;
   localparam logic [15:0] RFTX_ADDR_FRAME = 16'h1831;
   localparam logic [15:0] RFTX_ADDR_TXPWR = 16'h1832;
   localparam logic [15:0] RFTX_ADDR_CTRL8 = 16'h1837;
   // ****************************************
   // Fields and reset values
   // ****************************************
   localparam int RFTX_SEND_BIT = 7;
   localparam int RFTX_PWR_MSB = 4;
   localparam int RFTX_RST_BIT = 0;
   localparam logic [7:0] RFTX_RATE_RST = 8'h34;
   localparam logic [7:0] RFTX_FRAME_RST = 8'h00;
   localparam logic [4:0] RFTX_PWR_RST = 5'h00;
   // ****************************************
   // Timing
   // ****************************************
   localparam int RFTX_PRESCALE = 52;
   localparam int RFTX_CNT_W = 14;

   typedef struct packed {
      logic active;
      logic bit_tick;
      logic [7:0] bit_index;
      logic [4:0] power_select;
      logic rf_module_reset;
   } rftx_tx_t;
endpackage : rftx_pkg

// ---- src/rftx_regs.sv ----
/*
 * RF transmitter register bank: bit rate divider, frame bit count,
 * transmit start and power selection, module reset strobe, bit timer.
 * Assumes clk_sys is the crystal-derived clock that sets the bit rate
 * and that the data buffer follows tx.bit_index on each tx.bit_tick.
 */
// Our own choice: strobed register access.
//
// Contract
// - Bit period is 52 times divider plus one
// - Divider accepts all values 0x00 to 0xFF
// - Divider reads back last written value
// - Power-on reset loads divider with 52
// - Frame sends frame_bit_count plus one bits
// - Zero frame_bit_count sends nothing
// - Module reset clears frame_bit_count
// - Send bit 7, bits 6:5 reserved, power 4:0
// - Send starts, ends clear it, write zero aborts
// - Module reset clears power_select to zero
// - Module reset from power-on or control write
`timescale 1ns/1ns
module rftx_regs (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Register port
   input wire logic [15:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Transmitter side
   output rftx_pkg::rftx_tx_t tx
);
   // ****************************************
   // State
   // ****************************************
   localparam int RFTX_CNT_W = rftx_pkg::RFTX_CNT_W;
   logic [7:0] rate_divider_r, rate_divider_nxt;
   logic [7:0] frame_bit_count_r, frame_bit_count_nxt;
   logic send_r, send_nxt;
   logic [4:0] power_select_r, power_select_nxt;
   logic rf_module_reset_r, rf_module_reset_nxt;
   logic [rftx_pkg::RFTX_CNT_W-1:0] cnt_r, cnt_nxt;
   logic [7:0] bit_index_r, bit_index_nxt;
   logic tick_r, tick_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   logic [rftx_pkg::RFTX_CNT_W-1:0] reload;
   logic wr_rate, wr_frame, wr_txpwr, wr_ctrl8, mod_rst;

   function automatic logic hit(input logic [15:0] a, input logic [15:0] r);
      hit = (a == r);
   endfunction : hit

   assign wr_rate = reg_wr & hit(reg_addr, rftx_pkg::RFTX_ADDR_RATE);
   assign wr_frame = reg_wr & hit(reg_addr, rftx_pkg::RFTX_ADDR_FRAME);
   assign wr_txpwr = reg_wr & hit(reg_addr, rftx_pkg::RFTX_ADDR_TXPWR);
   assign wr_ctrl8 = reg_wr & hit(reg_addr, rftx_pkg::RFTX_ADDR_CTRL8);
   assign mod_rst = rf_module_reset_r;
   // Divide ratio minus one
   // Widest ratio, 52 times 256, still fits the bit timer
   assign reload = RFTX_CNT_W'(rftx_pkg::RFTX_PRESCALE
      * (int'(rate_divider_r) + 1) - 1);

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      rate_divider_nxt = rate_divider_r;
      frame_bit_count_nxt = frame_bit_count_r;
      send_nxt = send_r;
      power_select_nxt = power_select_r;
      cnt_nxt = cnt_r;
      bit_index_nxt = bit_index_r;
      tick_nxt = 1'b0;
      rf_module_reset_nxt = wr_ctrl8 & reg_wdata[rftx_pkg::RFTX_RST_BIT];
      if (wr_rate) begin
         rate_divider_nxt = reg_wdata;
      end
      if (wr_frame) begin
         frame_bit_count_nxt = reg_wdata;
      end
      if (send_r) begin
         if (cnt_r == '0) begin
            cnt_nxt = reload;
            tick_nxt = 1'b1;
         end else begin
            cnt_nxt = cnt_r - 1'b1;
         end
      end
      // Count frame bits, end after the last
      if (send_r && tick_r) begin
         if (bit_index_r == frame_bit_count_r) begin
            send_nxt = 1'b0;
         end else begin
            bit_index_nxt = bit_index_r + 8'h01;
         end
      end
      if (send_r && frame_bit_count_r == 8'h00) begin
         send_nxt = 1'b0;
      end
      // Software start or abort, module reset wins
      if (wr_txpwr) begin
         power_select_nxt = reg_wdata[rftx_pkg::RFTX_PWR_MSB:0];
         send_nxt = reg_wdata[rftx_pkg::RFTX_SEND_BIT];
         if (reg_wdata[rftx_pkg::RFTX_SEND_BIT] && !send_r) begin
            cnt_nxt = reload;
            bit_index_nxt = 8'h00;
         end
      end
      if (mod_rst) begin
         frame_bit_count_nxt = rftx_pkg::RFTX_FRAME_RST;
         power_select_nxt = rftx_pkg::RFTX_PWR_RST;
         send_nxt = 1'b0;
         bit_index_nxt = 8'h00;
         tick_nxt = 1'b0;
      end
   end

   // ****************************************
   // Read path
   // ****************************************
   always_comb begin
      rdata_nxt = 8'h00;
      if (reg_rd) begin
         if (hit(reg_addr, rftx_pkg::RFTX_ADDR_RATE)) begin
            rdata_nxt = rate_divider_r;
         end else if (hit(reg_addr, rftx_pkg::RFTX_ADDR_FRAME)) begin
            rdata_nxt = frame_bit_count_r;
         end else if (hit(reg_addr, rftx_pkg::RFTX_ADDR_TXPWR)) begin
            rdata_nxt = {send_r, 2'b00, power_select_r};
         end
      end
   end

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rate_divider_r <= rftx_pkg::RFTX_RATE_RST;
         frame_bit_count_r <= rftx_pkg::RFTX_FRAME_RST;
         send_r <= 1'b0;
         power_select_r <= rftx_pkg::RFTX_PWR_RST;
         rf_module_reset_r <= 1'b0;
         cnt_r <= '0;
         bit_index_r <= 8'h00;
         tick_r <= 1'b0;
         rdata_r <= 8'h00;
      end else begin
         rate_divider_r <= rate_divider_nxt;
         frame_bit_count_r <= frame_bit_count_nxt;
         send_r <= send_nxt;
         power_select_r <= power_select_nxt;
         rf_module_reset_r <= rf_module_reset_nxt;
         cnt_r <= cnt_nxt;
         bit_index_r <= bit_index_nxt;
         tick_r <= tick_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign reg_rdata = rdata_r;
   assign tx.active = send_r;
   assign tx.bit_tick = tick_r;
   assign tx.bit_index = bit_index_r;
   assign tx.power_select = power_select_r;
   assign tx.rf_module_reset = rf_module_reset_r | rst;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   tick_spacing_a: assert property (
      tick_r && send_r && !$past(wr_rate) |->
      cnt_r == reload) else $error("bit timer not reloaded on tick");
   rate_store_a: assert property (
      wr_rate |=> rate_divider_r == $past(reg_wdata))
      else $error("divider write lost");
   rate_read_a: assert property (
      reg_rd && hit(reg_addr, rftx_pkg::RFTX_ADDR_RATE) && !wr_rate |=>
      reg_rdata == rate_divider_r) else $error("divider readback wrong");
   rate_reset_a: assert property (
      $fell(rst) |-> rate_divider_r == rftx_pkg::RFTX_RATE_RST)
      else $error("divider reset value wrong");
   frame_end_a: assert property (
      send_r && tick_r && bit_index_r == frame_bit_count_r && !wr_txpwr
      && frame_bit_count_r != 8'h00 |=> !send_r)
      else $error("frame did not end on last bit");
   empty_frame_a: assert property (
      send_r && frame_bit_count_r == 8'h00 && !wr_txpwr |=> !send_r)
      else $error("empty frame still sending");
   frame_clear_a: assert property (
      mod_rst |=> frame_bit_count_r == 8'h00)
      else $error("module reset kept frame count");
   reserved_zero_a: assert property (
      reg_rd && hit(reg_addr, rftx_pkg::RFTX_ADDR_TXPWR) |=>
      reg_rdata[6:5] == 2'b00 && reg_rdata[7] == $past(send_r)
      && reg_rdata[4:0] == $past(power_select_r))
      else $error("status read layout wrong");
   send_abort_a: assert property (
      wr_txpwr && !reg_wdata[7] && !mod_rst |=> !send_r)
      else $error("abort did not stop send");
   power_clear_a: assert property (
      mod_rst |=> power_select_r == 5'h00 && !send_r)
      else $error("module reset kept power");
   mod_reset_a: assert property (
      wr_ctrl8 && reg_wdata[0] |=> tx.rf_module_reset ##1 !send_r)
      else $error("control write gave no module reset");
   tick_width_a: assert property (
      tick_r |=> !tick_r) else $error("bit tick longer than one cycle");
endmodule : rftx_regs

// ---- verification/rftx_regs_tb.sv ----
/* Self-checking bench for the rate and frame register bank.
   Assumes the design files under src/ are compiled before it. */
`timescale 1ns/1ns
module rftx_regs_tb;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [15:0] reg_addr = 16'h0000;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   rftx_pkg::rftx_tx_t tx;
   int n_mismatch = 0;
   int cmp_count = 0;
   int cyc = 0;
   int n_tick = 0;
   int last_tick = 0;
   int gap = 0;
   int t0;

   rftx_regs DUT (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .tx(tx));

   always #50 clk_sys = ~clk_sys;

   // ****************************************
   // Tick monitor and timeout
   // ****************************************
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (tx.bit_tick === 1'b1) begin
         n_tick <= n_tick + 1;
         gap <= cyc - last_tick;
         last_tick <= cyc;
      end
      if (cyc == 6000) begin
         n_mismatch = n_mismatch + 1;
         summarize();
      end
   end

   // ****************************************
   // Access tasks
   // ****************************************
   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
         n_mismatch = n_mismatch + 1;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask : wr

   task rd(input logic [15:0] a, input logic [7:0] exp);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      chk({24'h0, reg_rdata}, {24'h0, exp});
   endtask : rd

   task wait_idle;
      int i;
      for (i = 0; i < 2000; i++) begin
         @(posedge clk_sys);
         #1;
         if (tx.active === 1'b0) break;
      end
      chk({31'h0, tx.active}, 32'h0);
   endtask : wait_idle

   task summarize;
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : summarize

   // ****************************************
   // Test sequence
   // ****************************************
   initial begin
      repeat (2) @(posedge clk_sys);
      chk({31'h0, tx.rf_module_reset}, 32'h1);
      rst <= 1'b0;
      rd(16'h1830, 8'h34);
      chk({31'h0, tx.rf_module_reset}, 32'h0);
      rd(16'h1831, 8'h00);
      rd(16'h1832, 8'h00);
      rd(16'h1833, 8'h00);
      $display("test reset values done");
      wr(16'h1830, 8'hFF);
      rd(16'h1830, 8'hFF);
      wr(16'h1830, 8'hA5);
      rd(16'h1830, 8'hA5);
      $display("test divider readback done");
      t0 = n_tick;
      wr(16'h1832, 8'h80);
      repeat (60) @(posedge clk_sys);
      rd(16'h1832, 8'h00);
      chk(n_tick - t0, 32'd0);
      $display("test empty frame done");
      wr(16'h1830, 8'h01);
      wr(16'h1831, 8'h01);
      t0 = n_tick;
      wr(16'h1832, 8'h85);
      rd(16'h1832, 8'h85);
      chk({27'h0, tx.power_select}, 32'h05);
      wait_idle();
      chk(n_tick - t0, 32'd2);
      chk({24'h0, tx.bit_index}, 32'h01);
      chk(gap, 32'd52 * 2);
      rd(16'h1832, 8'h05);
      $display("test frame timing done");
      wr(16'h1831, 8'h03);
      t0 = n_tick;
      wr(16'h1832, 8'h80);
      repeat (10) @(posedge clk_sys);
      rd(16'h1832, 8'h80);
      wr(16'h1832, 8'h00);
      wait_idle();
      chk(n_tick - t0, 32'd0);
      rd(16'h1832, 8'h00);
      $display("test abort done");
      wr(16'h1831, 8'h10);
      wr(16'h1832, 8'h7F);
      rd(16'h1832, 8'h1F);
      wr(16'h1837, 8'h01);
      #1;
      chk({31'h0, tx.rf_module_reset}, 32'h1);
      rd(16'h1831, 8'h00);
      rd(16'h1832, 8'h00);
      rd(16'h1830, 8'h01);
      rd(16'h1837, 8'h00);
      $display("test module reset done");
      summarize();
   end
endmodule : rftx_regs_tb
